// [hw/adcsq_pkg.sv]
// Package of constants and types for the converter sequencer control block.
package adcsq_pkg;
  // Register offsets in data space.
  localparam logic [7:0] ADCSQ_RESULT_ADDR = 8'hd0;
  localparam logic [7:0] ADCSQ_CTRL_ADDR = 8'hd1;
  // Control register field positions.
  localparam int ADCSQ_IRQ_EN_BIT = 7;
  localparam int ADCSQ_DONE_BIT = 6;
  localparam int ADCSQ_START_BIT = 5;
  localparam int ADCSQ_POWER_BIT = 4;
  // Control register reset value.
  localparam logic [7:0] ADCSQ_CTRL_RESET = 8'h40;
  // Interrupt vector number of the end-of-conversion event.
  localparam logic [2:0] ADCSQ_IRQ_VECTOR = 3'h4;
  // Clock division factor and successive-approximation step count.
  localparam int ADCSQ_CLK_DIV = 12;
  localparam logic [3:0] ADCSQ_DIV_LAST = 4'(ADCSQ_CLK_DIV - 1);
  localparam int ADCSQ_RES_BITS = 8;
  localparam logic [2:0] ADCSQ_LAST_STEP = 3'h0;
  // Sequencer states.
  typedef enum logic [0:0] {
    ADCSQ_IDLE = 1'b0,
    ADCSQ_CONV = 1'b1
  } adcsq_state_t;
  // Core data-space access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcsq_bus_t;
endpackage : adcsq_pkg

// [hw/adcsq_divider.sv]
// Divide-by-twelve enable generator for the conversion clock.
`timescale 1ns/1ps
`default_nettype none
module adcsq_divider (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  import adcsq_pkg::*;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;

  always_comb begin
    if (restart || cnt_ff == ADCSQ_DIV_LAST) begin
      nxt_cnt = 4'h0;
    end else begin
      nxt_cnt = cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = (cnt_ff == ADCSQ_DIV_LAST) && !restart;

  tick_period_a: assert property (@(posedge core_clk) disable iff (rst)
    tick |=> !tick [*8] ##0 1) else $error("Divider tick repeats too soon.");
endmodule // adcsq_divider
`default_nettype wire

// [hw/adcsq_control.sv]
// Converter control and status logic with result register and step sequencer.
`timescale 1ns/1ps
`default_nettype none
module adcsq_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire adcsq_pkg::adcsq_bus_t bus,
  input wire logic cpu_wait,
  input wire logic comp_above,
  output logic [7:0] rdata,
  output logic [7:0] dac_code,
  output logic comparator_enable,
  output logic converting,
  output logic irq_req,
  output logic [2:0] irq_vector
);
  import adcsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic ctrl_wr;
  logic start_req;
  logic tick;
  logic irq_en_ff;
  logic done_ff;
  logic power_ff;
  logic [7:0] result_ff;
  logic [7:0] trial_ff;
  logic [2:0] step_ff;
  logic [7:0] rdata_ff;
  adcsq_state_t state_ff;

  assign ctrl_wr = bus.wr && (bus.addr == ADCSQ_CTRL_ADDR);
  assign start_req = ctrl_wr && bus.wdata[ADCSQ_START_BIT];

  adcsq_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .restart(start_req),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control bits.
  // reset to defaults.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en_ff <= ADCSQ_CTRL_RESET[ADCSQ_IRQ_EN_BIT];
      power_ff <= ADCSQ_CTRL_RESET[ADCSQ_POWER_BIT];
    end else if (ctrl_wr) begin
      irq_en_ff <= bus.wdata[ADCSQ_IRQ_EN_BIT];
      power_ff <= bus.wdata[ADCSQ_POWER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  logic last_step;
  assign last_step = (state_ff == ADCSQ_CONV) && tick && (step_ff == ADCSQ_LAST_STEP);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ADCSQ_IDLE;
      step_ff <= 3'h7;
    end else if (start_req) begin
      state_ff <= ADCSQ_CONV;
      step_ff <= 3'h7;
    end else begin
      unique case (state_ff)
        ADCSQ_IDLE: begin
          state_ff <= ADCSQ_IDLE;
        end
        ADCSQ_CONV: begin
          if (tick) begin
            if (step_ff != ADCSQ_LAST_STEP) begin
              step_ff <= step_ff - 3'h1;
            end else begin
              state_ff <= ADCSQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trial code, one flip-flop per bit.
  // per-bit trial update.
  for (genvar b = 0; b < ADCSQ_RES_BITS; b++) begin : g_trial
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        trial_ff[b] <= 1'(b == ADCSQ_RES_BITS - 1);
      end else if (start_req) begin
        trial_ff[b] <= 1'(b == ADCSQ_RES_BITS - 1);
      end else if (state_ff == ADCSQ_CONV && tick) begin
        if (step_ff == 3'(b)) begin
          trial_ff[b] <= comp_above;
        end else if (b < ADCSQ_RES_BITS - 1 && step_ff == 3'(b + 1)) begin
          trial_ff[b] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_ff <= 8'h00;
    end else if (last_step && !start_req) begin
      result_ff <= comp_above ? trial_ff : (trial_ff & ~8'h01);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_ff <= ADCSQ_CTRL_RESET[ADCSQ_DONE_BIT];
    end else if (start_req) begin
      done_ff <= 1'b0;
    end else if (last_step) begin
      done_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and outputs.
  // start reads zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      if (bus.addr == ADCSQ_CTRL_ADDR) begin
        rdata_ff <= {irq_en_ff, done_ff, 1'b0, power_ff, 4'h0};
      end else if (bus.addr == ADCSQ_RESULT_ADDR) begin
        rdata_ff <= result_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign rdata = rdata_ff;
  assign dac_code = trial_ff;
  assign comparator_enable = power_ff;
  assign converting = (state_ff == ADCSQ_CONV);
  assign irq_req = irq_en_ff && done_ff;
  assign irq_vector = ADCSQ_IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence start_seq;
    start_req;
  endsequence
  sequence done_seq;
    done_ff;
  endsequence

  start_clears_a: assert property (@(posedge core_clk) disable iff (rst)
    start_seq |=> !done_ff && converting) else $error("Start did not clear done.");
  conv_time_a: assert property (@(posedge core_clk) disable iff (rst)
    start_seq ##1 (!start_req) [*8] |-> !done_ff) else $error("Done came too early.");
  finish_done_a: assert property (@(posedge core_clk) disable iff (rst)
    last_step && !start_req |=> done_seq and !converting) else $error("Done not set.");
  single_shot_a: assert property (@(posedge core_clk) disable iff (rst)
    !converting && !start_req |=> !converting) else $error("Conversion began alone.");
  restart_conv_a: assert property (@(posedge core_clk) disable iff (rst)
    converting && start_req |=> converting && step_ff == 3'h7) else $error("No restart.");
  start_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    bus.rd && bus.addr == ADCSQ_CTRL_ADDR |=> !rdata[ADCSQ_START_BIT])
    else $error("Start bit read back.");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_req |-> irq_en_ff && done_ff && irq_vector == 3'h4) else $error("Bad interrupt.");
  power_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_wr |=> comparator_enable == $past(bus.wdata[ADCSQ_POWER_BIT]))
    else $error("Power bit ignored.");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on the default clock.
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence step_seq;
    converting && tick && !start_req;
  endsequence

  logic [6:0] conv_cnt_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_cnt_ff <= 7'h00;
    end else if (start_req) begin
      conv_cnt_ff <= 7'h00;
    end else if (converting) begin
      conv_cnt_ff <= conv_cnt_ff + 7'h01;
    end
  end

  conv_len_a: assert property (
    last_step |-> conv_cnt_ff == 7'(ADCSQ_CLK_DIV * ADCSQ_RES_BITS - 1))
    else $error("Conversion length wrong.");

  conv_max_a: assert property (
    converting |-> conv_cnt_ff <= 7'(ADCSQ_CLK_DIV * ADCSQ_RES_BITS - 1))
    else $error("Conversion ran too long.");

  start_tick_a: assert property (
    start_req |=> !tick)
    else $error("Tick right after start.");

  done_rise_a: assert property (
    $rose(done_ff) |-> $past(last_step))
    else $error("Done rose without a finish.");

  done_hold_a: assert property (
    done_ff && !start_req |=> done_ff)
    else $error("Done dropped without a start.");

  idle_dac_a: assert property (
    !converting && !start_req |=> $stable(dac_code))
    else $error("Trial code moved while idle.");

  irq_on_done_a: assert property (
    irq_en_ff && done_ff |-> irq_req && irq_vector == ADCSQ_IRQ_VECTOR)
    else $error("Interrupt missing.");

  irq_mask_a: assert property (
    !irq_en_ff |-> !irq_req)
    else $error("Masked interrupt raised.");

  ctrl_read_a: assert property (
    bus.rd && bus.addr == ADCSQ_CTRL_ADDR |=> rdata == {$past(irq_en_ff), $past(done_ff), 1'b0,
      $past(power_ff), 4'h0})
    else $error("Control read wrong.");

  comp_power_a: assert property (
    !power_ff |-> !comparator_enable)
    else $error("Comparator on while powered down.");

  wait_keep_a: assert property (
    cpu_wait |-> comparator_enable == power_ff)
    else $error("Wait state changed power.");

  reset_idle_a: assert property (
    $fell(rst) |-> !converting && !irq_req && dac_code == 8'h80)
    else $error("Reset left activity.");

  result_hold_a: assert property (
    !last_step |=> $stable(result_ff))
    else $error("Result changed without a finish.");

  result_read_a: assert property (
    bus.rd && bus.addr == ADCSQ_RESULT_ADDR |=> rdata == $past(result_ff))
    else $error("Result read wrong.");

  unmapped_zero_a: assert property (
    bus.rd && bus.addr != ADCSQ_RESULT_ADDR && bus.addr != ADCSQ_CTRL_ADDR |=> rdata == 8'h00)
    else $error("Unmapped read not zero.");

  step_hold_a: assert property (
    converting && !tick && !start_req |=> $stable(step_ff) && $stable(trial_ff))
    else $error("Step moved without a tick.");

  msb_first_a: assert property (
    step_seq ##0 (step_ff != ADCSQ_LAST_STEP) |=> step_ff == $past(step_ff) - 3'h1)
    else $error("Step order wrong.");
endmodule // adcsq_control
`default_nettype wire

// [tb/adcsq_comp_model.sv]
// Behavioural model of the analog input, trial converter and comparator.
`timescale 1ns/1ps
`default_nettype none
module adcsq_comp_model (
  input wire logic core_clk,
  input wire logic [7:0] vin,
  input wire logic [7:0] dac_code,
  input wire logic comparator_enable,
  output logic comp_above
);
  logic junk_ff = 1'b0;
  always @(posedge core_clk) begin
    junk_ff <= ~junk_ff;
  end
  // one input: a single analog level feeds the comparator.
  // power first: an unpowered comparator gives a changing pattern.
  assign comp_above = comparator_enable ? (vin >= dac_code) : junk_ff;
endmodule // adcsq_comp_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcsq_pkg::*;
  typedef struct packed {logic [7:0] v; logic [7:0] ctl; logic [7:0] st; logic irq;} adcsq_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  adcsq_bus_t bus = '0;
  logic cpu_wait = 1'b0;
  logic [7:0] vin = 8'h00;
  logic comp_above;
  logic [7:0] rdata;
  logic [7:0] dac_code;
  logic comparator_enable;
  logic converting;
  logic irq_req;
  logic [2:0] irq_vector;
  int err_total = 0;
  int num_checks = 0;
  adcsq_row_t rows [4] = '{{8'h00, 8'h30, 8'h50, 1'b0}, {8'hff, 8'hb0, 8'hd0, 1'b1},
                           {8'h80, 8'h30, 8'h50, 1'b0}, {8'h5a, 8'hb0, 8'hd0, 1'b1}};
  always #20 core_clk = ~core_clk;
  adcsq_control i_adcsq_control (.core_clk(core_clk), .rst(rst), .bus(bus),
    .cpu_wait(cpu_wait), .comp_above(comp_above), .rdata(rdata), .dac_code(dac_code),
    .comparator_enable(comparator_enable), .converting(converting), .irq_req(irq_req),
    .irq_vector(irq_vector));
  adcsq_comp_model i_adcsq_comp_model (.core_clk(core_clk), .vin(vin), .dac_code(dac_code),
    .comparator_enable(comparator_enable), .comp_above(comp_above));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(posedge core_clk);
    #1 bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    #1 bus.rd = 1'b1;
    bus.addr = a;
    @(posedge core_clk);
    #1 bus.rd = 1'b0;
    chk(what, exp, rdata);
  endtask
  task automatic conv(input logic [7:0] v, input logic [7:0] ctl);
    vin = v;
    wr(ADCSQ_CTRL_ADDR, ctl);
    chk("dac_code", 8'h80, dac_code);
    repeat (95) @(posedge core_clk);
    #1 chk("busy", 8'h01, 8'(converting));
    chk("irq busy", 8'h00, 8'(irq_req));
    @(posedge core_clk);
    #1 chk("busy end", 8'h00, 8'(converting));
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    rd(ADCSQ_CTRL_ADDR, ADCSQ_CTRL_RESET, "ctrl reset");
    rd(ADCSQ_RESULT_ADDR, 8'h00, "result reset");
    chk("vector", 8'h04, 8'(irq_vector));
    wr(ADCSQ_CTRL_ADDR, 8'h10);
    foreach (rows[i]) begin
      conv(rows[i].v, rows[i].ctl);
      rd(ADCSQ_RESULT_ADDR, rows[i].v, "result");
      rd(ADCSQ_CTRL_ADDR, rows[i].st, "ctrl done");
      chk("irq", 8'(rows[i].irq), 8'(irq_req));
    end
    wr(ADCSQ_RESULT_ADDR, 8'h11);
    rd(ADCSQ_RESULT_ADDR, 8'h5a, "result write");
    rd(8'hd2, 8'h00, "unmapped");
    wr(ADCSQ_CTRL_ADDR, 8'h10);
    rd(ADCSQ_CTRL_ADDR, 8'h50, "done kept");
    repeat (200) @(posedge core_clk);
    #1 chk("single shot", 8'h00, 8'(converting));
    vin = 8'h33;
    wr(ADCSQ_CTRL_ADDR, 8'h30);
    repeat (40) @(posedge core_clk);
    rd(ADCSQ_CTRL_ADDR, 8'h10, "ctrl busy");
    // wait mode: the core idles while the conversion runs.
    cpu_wait = 1'b1;
    conv(8'h33, 8'h30);
    chk("wait power", 8'h01, 8'(comparator_enable));
    cpu_wait = 1'b0;
    rd(ADCSQ_RESULT_ADDR, 8'h33, "restart result");
    wr(ADCSQ_CTRL_ADDR, 8'h00);
    chk("power off", 8'h00, 8'(comparator_enable));
    wr(ADCSQ_CTRL_ADDR, 8'h10);
    wr(ADCSQ_CTRL_ADDR, 8'hb0);
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b1;
    @(posedge core_clk);
    #1 chk("reset halt", 8'h00, 8'(converting));
    rst = 1'b0;
    rd(ADCSQ_CTRL_ADDR, ADCSQ_CTRL_RESET, "ctrl rereset");
    chk("irq reset", 8'h00, 8'(irq_req));
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
